/* cfg_hdr_regs.sv */
// Purpose: command, status, identity, cache line and latency timer registers
// Assumes: configuration decode and bus state machines live outside this block
// Notes:   one configuration access per cycle, reads answered from flip-flops
//
// Operation
// - io decode needs command bit 0 and D0
// - memory decode needs bit 1 and D0
// - bus mastering needs bit 2 and D0
// - write invalidate only when bit 4 set
// - bit 6 parity reaction, resets to zero
// - bit 8 gates system error driver
// - all-zero command detaches except configuration
// - status bit 4 reads one
// - status bit 7 reads one
// - bit 8 set on master perr seen, only while bit 6 set
// - bits 10:9 read 01, medium select
// - bit 11 set on target abort sent
// - bits 12, 13 on received aborts
// - bit 14 set when system error driven
// - bit 15 set on any parity error
// - status writes clear ones, never set
// - read-only 8-bit silicon revision code
// - class code reads token ring controller
// - only cache sizes 4..64 powers honoured
// - hold timer starts at frame, release on expiry once grant is gone
// - hold timer low three bits zero
// - layout type reads 00h
// - claim only type 0 function 0
`timescale 1ns/100ps
module cfg_hdr_regs #(
  parameter logic [7:0] SILICON_REV = 8'h01  // arbitrary neutral value
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // configuration access, already qualified by the select strobe
  input  wire logic        i_cfg_valid,      // one-cycle access strobe
  input  wire logic        i_cfg_write,      // 1 write, 0 read
  input  wire logic        i_cfg_type1,      // address type bit set
  input  wire logic [2:0]  i_cfg_func,       // function number
  input  wire logic [7:0]  i_cfg_addr,       // byte address, low 2 bits ignored
  input  wire logic [3:0]  i_cfg_byte_en,    // active-high lane enables
  input  wire logic [31:0] i_cfg_wdata,      // write data
  // power state, request, grant and busy levels, bus events (one-cycle pulses)
  input  wire logic [1:0]  i_power_state,    // current power state
  input  wire logic        i_mst_perr_pulse, // perr seen while mastering
  input  wire logic        i_tgt_abort_sent, // we ended a target cycle with abort
  input  wire logic        i_tgt_abort_got,  // our master cycle target-aborted
  input  wire logic        i_mst_abort_got,  // our master cycle master-aborted
  input  wire logic        i_parity_err,     // any parity error detected
  input  wire logic        i_syserr_req,     // core wants to signal system error
  input  wire logic        i_frame_start,    // we assert frame this cycle
  input  wire logic        i_gnt_active,     // grant currently asserted
  input  wire logic        i_mst_busy,       // our master cycle in progress
  // answers
  output logic             o_cfg_claim,      // configuration access claimed
  output logic             o_cfg_rvalid,     // read data valid
  output logic [31:0]      o_cfg_rdata,      // read data
  output logic             o_io_decode_en,   // may answer io cycles
  output logic             o_mem_decode_en,  // may answer memory cycles
  output logic             o_initiator_en,   // may start master cycles
  output logic             o_write_invalidate_en, // may issue write-invalidate
  output logic             o_parity_react_en,     // take action on parity
  output logic             o_syserr_out,     // system error driven low level value
  output logic             o_syserr_oe,      // system error driver enable
  output logic [1:0]       o_select_speed_code,   // advertised select speed
  output logic [7:0]       o_cache_line_eff, // honoured cache size in dwords
  output logic             o_hold_expired,   // hold timer ran out
  output logic             o_release_bus     // give up the bus now
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [15:0] command;     // writable command bits
    logic [7:0]  flags;       // sticky status bits 15..8
    logic [7:0]  cache_line;  // cache line size as written
    logic [7:0]  hold_timer;  // programmed hold time
    logic [7:0]  hold_count;  // running count
    logic        hold_run;    // counting active
    logic        rvalid;      // read answer pulse
    logic        claim;       // claim pulse
    logic [31:0] rdata;       // read data
  } state_type;

  state_type cur_ff;      // registered state
  state_type nxt_cur;     // next state

  logic      access_hit;  // access is ours
  logic [15:0] status_rd; // status as read
  logic [15:0] clear_bits;// status bits cleared by write
  logic [7:0]  set_bits;  // status bits set by events

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // merge write data into a byte under its lane enable
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] wr,
                                      input logic en);
    lane = en ? wr : old;
  endfunction

  // honoured cache size: powers of two 4..64, else zero
  function automatic logic [7:0] cache_ok(input logic [7:0] v);
    unique case (v)
      8'h04, 8'h08, 8'h10, 8'h20, 8'h40: cache_ok = v;
      default:                           cache_ok = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode and status assembly
  always_comb begin
    // only type 0 to function 0 is ours
    access_hit = i_cfg_valid && !i_cfg_type1 && (i_cfg_func == 3'h0);
    // undefined bits stay zero
    status_rd  = {cur_ff.flags, 8'h00} | cfg_hdr_pkg::ST_CONST;
    clear_bits = 16'h0000;
    if (access_hit && i_cfg_write && (i_cfg_addr[7:2] == cfg_hdr_pkg::DW_CMD_STAT[7:2])) begin
      clear_bits = {i_cfg_wdata[31:24] & {8{i_cfg_byte_en[3]}},
                    i_cfg_wdata[23:16] & {8{i_cfg_byte_en[2]}}};
    end
    set_bits = 8'h00;
    set_bits[cfg_hdr_pkg::ST_MPERR-8]   = i_mst_perr_pulse
                                          && cur_ff.command[cfg_hdr_pkg::CMD_PERR];
    set_bits[cfg_hdr_pkg::ST_TA_SENT-8] = i_tgt_abort_sent;
    set_bits[cfg_hdr_pkg::ST_TA_GOT-8]  = i_tgt_abort_got;
    set_bits[cfg_hdr_pkg::ST_MA_GOT-8]  = i_mst_abort_got;
    set_bits[cfg_hdr_pkg::ST_SERR-8]    = o_syserr_oe;
    set_bits[cfg_hdr_pkg::ST_PERR-8]    = i_parity_err;
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.rvalid = 1'b0;
    nxt_cur.claim  = access_hit;
    // sticky flags: event wins over a same-cycle clear
    nxt_cur.flags  = (cur_ff.flags & ~clear_bits[15:8]) | set_bits;
    // writes
    if (access_hit && i_cfg_write) begin
      unique case (i_cfg_addr[7:2])
        cfg_hdr_pkg::DW_CMD_STAT[7:2]: begin
          // only defined bits take the write
          nxt_cur.command = {lane(cur_ff.command[15:8], i_cfg_wdata[15:8], i_cfg_byte_en[1]),
                             lane(cur_ff.command[7:0], i_cfg_wdata[7:0], i_cfg_byte_en[0])}
                            & cfg_hdr_pkg::CMD_WR_MASK;
        end
        cfg_hdr_pkg::DW_CACHE_LAT[7:2]: begin
          nxt_cur.cache_line = lane(cur_ff.cache_line, i_cfg_wdata[7:0], i_cfg_byte_en[0]);
          nxt_cur.hold_timer = lane(cur_ff.hold_timer, i_cfg_wdata[15:8], i_cfg_byte_en[1])
                               & cfg_hdr_pkg::LAT_WR_MASK;
        end
        default: begin
          // read-only or unmapped: write ignored
        end
      endcase
    end
    // reads
    if (access_hit && !i_cfg_write) begin
      nxt_cur.rvalid = 1'b1;
      unique case (i_cfg_addr[7:2])
        cfg_hdr_pkg::DW_CMD_STAT[7:2]:
          nxt_cur.rdata = {status_rd, cur_ff.command};
        cfg_hdr_pkg::DW_REV_CLASS[7:2]:
          nxt_cur.rdata = {cfg_hdr_pkg::CLASS_TOKEN_RING, SILICON_REV};
        cfg_hdr_pkg::DW_CACHE_LAT[7:2]:
          nxt_cur.rdata = {8'h00, cfg_hdr_pkg::LAYOUT_TYPE0,
                           cur_ff.hold_timer, cur_ff.cache_line};
        default:
          nxt_cur.rdata = 32'h00000000; // reserved space reads zero
      endcase
    end
    // hold timer restarts on each frame start, stops when the cycle ends
    if (i_frame_start) begin
      nxt_cur.hold_run   = 1'b1;
      nxt_cur.hold_count = cur_ff.hold_timer;
    end else if (!i_mst_busy) begin
      nxt_cur.hold_run   = 1'b0;
    end else if (cur_ff.hold_run && (cur_ff.hold_count != 8'h00)) begin
      nxt_cur.hold_count = cur_ff.hold_count - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cur_ff            <= '0;
      cur_ff.command    <= cfg_hdr_pkg::CMD_RESET;
      cur_ff.cache_line <= cfg_hdr_pkg::CACHE_RESET;
      cur_ff.hold_timer <= cfg_hdr_pkg::LAT_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  logic in_d0;  // full power
  assign in_d0 = (i_power_state == cfg_hdr_pkg::PWR_D0);

  // an all-zero command leaves every enable low, so only configuration passes
  assign o_io_decode_en  = cur_ff.command[cfg_hdr_pkg::CMD_IO] && in_d0;
  assign o_mem_decode_en = cur_ff.command[cfg_hdr_pkg::CMD_MEM] && in_d0;
  assign o_initiator_en  = cur_ff.command[cfg_hdr_pkg::CMD_MST] && in_d0;
  assign o_write_invalidate_en = cur_ff.command[cfg_hdr_pkg::CMD_MWI]
                                 && o_initiator_en;
  assign o_parity_react_en = cur_ff.command[cfg_hdr_pkg::CMD_PERR];
  // open-drain: drive low only when allowed
  assign o_syserr_out = 1'b0;
  assign o_syserr_oe  = i_syserr_req && cur_ff.command[cfg_hdr_pkg::CMD_SERR];
  assign o_select_speed_code = cfg_hdr_pkg::SELECT_MEDIUM;
  assign o_cache_line_eff = cache_ok(cur_ff.cache_line);
  assign o_hold_expired = cur_ff.hold_run && (cur_ff.hold_count == 8'h00);
  assign o_release_bus  = o_hold_expired && !i_gnt_active;
  assign o_cfg_claim  = cur_ff.claim;
  assign o_cfg_rvalid = cur_ff.rvalid;
  assign o_cfg_rdata  = cur_ff.rdata;

endmodule

/* cfg_hdr_pkg.sv */
// Purpose: constants for the configuration header register block
// Assumes: dword-wide configuration access, byte enables per lane
// Notes:   offsets are byte addresses within configuration space
package cfg_hdr_pkg;
  // dword addresses (byte offset of the aligned dword)
  localparam logic [7:0] DW_CMD_STAT   = 8'h04;
  localparam logic [7:0] DW_REV_CLASS  = 8'h08;
  localparam logic [7:0] DW_CACHE_LAT  = 8'h0C;
  // byte offsets as printed
  localparam logic [7:0] OFS_COMMAND   = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h06;
  localparam logic [7:0] OFS_REVISION  = 8'h08;
  localparam logic [7:0] OFS_CLASS     = 8'h09;
  localparam logic [7:0] OFS_CACHE     = 8'h0C;
  localparam logic [7:0] OFS_LATENCY   = 8'h0D;
  localparam logic [7:0] OFS_LAYOUT    = 8'h0E;
  // command bit positions
  localparam int CMD_IO     = 0;
  localparam int CMD_MEM    = 1;
  localparam int CMD_MST    = 2;
  localparam int CMD_MWI    = 4;
  localparam int CMD_PERR   = 6;
  localparam int CMD_SERR   = 8;
  // implemented command bits
  localparam logic [15:0] CMD_WR_MASK  = 16'h0157;
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  // status bit positions
  localparam int ST_CAP     = 4;
  localparam int ST_B2B     = 7;
  localparam int ST_MPERR   = 8;
  localparam int ST_TA_SENT = 11;
  localparam int ST_TA_GOT  = 12;
  localparam int ST_MA_GOT  = 13;
  localparam int ST_SERR    = 14;
  localparam int ST_PERR    = 15;
  // constant status bits: capability list, fast b2b, medium select speed
  localparam logic [15:0] ST_CONST     = 16'h0290;
  localparam logic [1:0]  SELECT_MEDIUM = 2'h1;
  // fixed identity fields, cache and latency reset values, latency write mask
  localparam logic [23:0] CLASS_TOKEN_RING = 24'h020100;
  localparam logic [7:0]  LAYOUT_TYPE0     = 8'h00;
  localparam logic [7:0]  CACHE_RESET      = 8'h00;
  localparam logic [7:0]  LAT_RESET        = 8'h00;
  localparam logic [7:0]  LAT_WR_MASK      = 8'hF8;
  // power state code for full power
  localparam logic [1:0]  PWR_D0           = 2'h0;
endpackage

/* cfg_hdr_regs_props.sv */
// Purpose: port checks for the header register block
// Assumes: one clock, sync reset
// Notes:   bound below the module
`timescale 1ns/100ps
module cfg_hdr_regs_props (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_cfg_valid,
  input wire logic       i_cfg_write,
  input wire logic       i_cfg_type1,
  input wire logic [2:0] i_cfg_func,
  input wire logic [1:0] i_power_state,
  input wire logic       i_syserr_req,
  input wire logic       i_gnt_active,
  input wire logic       o_cfg_claim,
  input wire logic       o_cfg_rvalid,
  input wire logic       o_io_decode_en,
  input wire logic       o_mem_decode_en,
  input wire logic       o_initiator_en,
  input wire logic       o_write_invalidate_en,
  input wire logic       o_syserr_oe,
  input wire logic [1:0] o_select_speed_code,
  input wire logic [7:0] o_cache_line_eff,
  input wire logic       o_hold_expired,
  input wire logic       o_release_bus
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////
  AST_CLAIM: assert property (
    o_cfg_claim |-> $past(i_cfg_valid && !i_cfg_type1 && i_cfg_func == 3'h0))
    else $error("claim without a type 0 function 0 access");
  AST_READ: assert property (
    i_cfg_valid && !i_cfg_write && !i_cfg_type1 && i_cfg_func == 3'h0
    |=> o_cfg_claim && o_cfg_rvalid) else $error("read not answered");
  AST_DECODE: assert property (
    o_io_decode_en || o_mem_decode_en || o_initiator_en |-> i_power_state == 2'h0)
    else $error("decode enabled outside full power");
  AST_MWI: assert property (o_write_invalidate_en |-> o_initiator_en)
    else $error("write invalidate without mastering");
  AST_SYSERR: assert property (o_syserr_oe |-> i_syserr_req)
    else $error("system error driven without request");
  AST_SPEED: assert property (o_select_speed_code == 2'h1)
    else $error("select speed code wrong");
  AST_CACHE: assert property (
    o_cache_line_eff inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40})
    else $error("unsupported cache size honoured");
  AST_RELEASE: assert property (
    o_release_bus == (o_hold_expired && !i_gnt_active))
    else $error("bus release wrong");
  cover property (o_cfg_rvalid);
  cover property (o_release_bus);
  cover property (o_syserr_oe);
endmodule
bind cfg_hdr_regs cfg_hdr_regs_props props (.*);

/* cfg_host_model.sv */
// Purpose: configuration master stand-in
// Assumes: one access in flight at a time
// Notes:   drives 1 ns after the rising edge
`timescale 1ns/100ps
module cfg_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_claim,
  input  wire logic [31:0] i_rdata,
  output logic             o_valid,
  output logic             o_write,
  output logic             o_type1,
  output logic [2:0]       o_func,
  output logic [7:0]       o_addr,
  output logic [3:0]       o_be,
  output logic [31:0]      o_wdata
);
  initial {o_valid, o_write, o_type1, o_func, o_addr, o_be, o_wdata} = '0;
  ////////////////////////////////////////
  // one strobe cycle, answer taken at the following edge
  task automatic xfer(input logic w, t1, input logic [2:0] f, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] d, output logic cl, output logic [31:0] rd);
    @(posedge i_clk) #1;
    {o_valid, o_write, o_type1, o_func, o_addr, o_be, o_wdata} = {1'b1, w, t1, f, a, be, d};
    @(posedge i_clk) #1;
    o_valid = 1'b0;
    o_wdata = ~d; // released data must not keep its value
    cl = i_claim;
    rd = i_rdata;
  endtask
endmodule

/* pci_config_header_regs_tb.sv */
// Purpose: self-checking bench for the header register block
// Assumes: host model issues the configuration accesses
// Notes:   expectations come from package constants
`timescale 1ns/100ps
module pci_config_header_regs_tb;
  localparam logic [7:0] REV = 8'h5A; // arbitrary value
  logic clk, rst, vld, w, t1, cl, sreq, fs, gnt, busy, claim, rv, ioe, meme, inie, mwie, pre;
  logic sout, soe, hexp, rel;
  logic [2:0] fn;
  logic [7:0] ad, ce;
  logic [3:0] be;
  logic [31:0] wd, rd, rdat;
  logic [1:0] pwr, spd;
  logic [4:0] ev; // perr seen, abort sent, target abort, master abort, parity
  int mismatches, samples_checked, cyc;
  int pos[5] = '{8, 11, 12, 13, 15};
  logic [7:0] cs[4] = '{8'h04, 8'h40, 8'h0C, 8'h80};
  logic [7:0] ceff[4] = '{8'h04, 8'h40, 8'h00, 8'h00};
  cfg_host_model host (.i_clk(clk), .i_claim(claim), .i_rdata(rdat), .o_valid(vld),
    .o_write(w), .o_type1(t1), .o_func(fn), .o_addr(ad), .o_be(be), .o_wdata(wd));
  cfg_hdr_regs #(.SILICON_REV(REV)) dut (.i_clk(clk), .i_reset(rst), .i_cfg_valid(vld),
    .i_cfg_write(w), .i_cfg_type1(t1), .i_cfg_func(fn), .i_cfg_addr(ad), .i_cfg_byte_en(be),
    .i_cfg_wdata(wd), .i_power_state(pwr), .i_mst_perr_pulse(ev[0]), .i_tgt_abort_sent(ev[1]),
    .i_tgt_abort_got(ev[2]), .i_mst_abort_got(ev[3]), .i_parity_err(ev[4]),
    .i_syserr_req(sreq), .i_frame_start(fs), .i_gnt_active(gnt), .i_mst_busy(busy),
    .o_cfg_claim(claim), .o_cfg_rvalid(rv), .o_cfg_rdata(rdat), .o_io_decode_en(ioe),
    .o_mem_decode_en(meme), .o_initiator_en(inie), .o_write_invalidate_en(mwie),
    .o_parity_react_en(pre), .o_syserr_out(sout), .o_syserr_oe(soe),
    .o_select_speed_code(spd), .o_cache_line_eff(ce), .o_hold_expired(hexp),
    .o_release_bus(rel));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d);
    host.xfer(wr, 1'b0, 3'h0, a, b, d, cl, rd);
    check("claim", {31'h0, cl}, 32'h1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 4'h0, 32'h0);
    check("rdata", rd, exp);
    check("rvalid", {31'h0, rv}, 32'h1);
  endtask
  task automatic t_reset();
    @(posedge clk) #1 rst = 1'b1;
    @(posedge clk) #1 rst = 1'b0;
    check("reset enables", {27'h0, ioe, meme, inie, mwie, pre}, 32'h0);
    rdchk(8'h04, {cfg_hdr_pkg::ST_CONST, cfg_hdr_pkg::CMD_RESET});
  endtask
  task automatic t_idents();
    rdchk(8'h04, {cfg_hdr_pkg::ST_CONST, cfg_hdr_pkg::CMD_RESET});
    rdchk(8'h08, {cfg_hdr_pkg::CLASS_TOKEN_RING, REV});
    rdchk(8'h0C, 32'h0);
    check("speed code", {30'h0, spd}, {30'h0, cfg_hdr_pkg::SELECT_MEDIUM});
    check("syserr level", {31'h0, sout}, 32'h0);
  endtask
  task automatic t_command();
    acc(1'b1, 8'h04, 4'h3, 32'h0000_FFFF);
    rdchk(8'h04, {cfg_hdr_pkg::ST_CONST, cfg_hdr_pkg::CMD_WR_MASK});
    check("enables", {27'h0, ioe, meme, inie, mwie, pre}, 32'h1F);
    pwr = 2'h3;
    #1 check("low power", {28'h0, ioe, meme, inie, mwie}, 32'h0);
    pwr = 2'h0;
    acc(1'b1, 8'h04, 4'h3, 32'h0);
    check("detached", {27'h0, ioe, meme, inie, mwie, pre}, 32'h0);
  endtask
  task automatic t_status();
    acc(1'b1, 8'h04, 4'h3, 32'h0000_0140);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) #1 ev[i] = 1'b1;
      @(posedge clk) #1 ev = 5'h0;
      acc(1'b1, 8'h04, 4'hC, 32'h0); // zeros leave flags alone
      rdchk(8'h04, {cfg_hdr_pkg::ST_CONST | (16'h1 << pos[i]), 16'h0140});
      acc(1'b1, 8'h04, 4'hC, 32'hFFFF_0000);
      rdchk(8'h04, {cfg_hdr_pkg::ST_CONST, 16'h0140});
    end
    sreq = 1'b1;
    #1 check("serr oe", {31'h0, soe}, 32'h1);
    acc(1'b1, 8'h04, 4'h3, 32'h0000_0040);
    check("serr off", {31'h0, soe}, 32'h0);
    sreq = 1'b0;
    rdchk(8'h04, {cfg_hdr_pkg::ST_CONST | 16'h4000, 16'h0040});
  endtask
  task automatic t_cache();
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h0C, 4'h3, {16'h0, 8'hFF, cs[i]});
      check("cache eff", {24'h0, ce}, {24'h0, ceff[i]});
      rdchk(8'h0C, {16'h0, 8'hF8, cs[i]});
    end
  endtask
  task automatic t_timer();
    acc(1'b1, 8'h0C, 4'h3, 32'h0000_0800);
    @(posedge clk) #1 {fs, busy, gnt} = 3'b111;
    @(posedge clk) #1 fs = 1'b0;
    repeat (4) @(posedge clk);
    #1 check("early expiry", {31'h0, hexp}, 32'h0);
    repeat (6) @(posedge clk);
    #1 check("expired", {30'h0, hexp, rel}, 32'h2);
    gnt = 1'b0;
    #1 check("release", {31'h0, rel}, 32'h1);
    busy = 1'b0;
  endtask
  task automatic t_refuse();
    host.xfer(1'b0, 1'b1, 3'h0, 8'h04, 4'h0, 32'h0, cl, rd);
    check("type1", {31'h0, cl}, 32'h0);
    host.xfer(1'b1, 1'b0, 3'h1, 8'h04, 4'h3, 32'h0000_0007, cl, rd);
    check("func1", {31'h0, cl, ioe}, 32'h0);
    acc(1'b1, 8'h08, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h08, {cfg_hdr_pkg::CLASS_TOKEN_RING, REV});
    rdchk(8'h40, 32'h0);
  endtask
  task automatic final_report();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {rst, pwr, ev, sreq, fs, gnt, busy} = 12'h800;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_idents();
    t_command();
    t_status();
    t_cache();
    t_timer();
    t_refuse();
    t_reset();
    final_report();
  end
endmodule
